/* File: core/alu_defines.vh */
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH

// apb register byte offsets
`define ADDR_INSTR        12'h000
`define ADDR_ACC          12'h004
`define ADDR_STATUS       12'h008
`define ADDR_PTR0         12'h00C
`define ADDR_PTR1         12'h010
`define ADDR_FILE_BASE    12'h200
`define ADDR_FILE_TOP     12'h3FC

// status register fields
`define ST_CARRY          0
`define ST_DIGIT_CARRY    1
`define ST_ZERO           2
`define ST_BUSY           3

// opcode fields
`define OPC_TOP6_MSB      13
`define OPC_TOP6_LSB      8
`define OPC_ACC_ADD_LIT   6'h3E
`define OPC_ACC_AND_LIT   6'h39
`define OPC_ACC_ADD_REG   6'h07
`define OPC_ACC_AND_REG   6'h05
`define OPC_ACC_ADD_CARRY 6'h3D
`define OPC_ARITH_SHIFT   6'h37
`define OPC_PTR_ADD       7'h62
`define OPC_BIT_CLEAR     4'h4
`define OPC_DEST_BIT      7
`define OPC_PTR_SEL_BIT   6
`define OPC_NIBBLE_CARRY  4

// internal operation codes
`define OP_NONE           3'h0
`define OP_ADD            3'h1
`define OP_ADD_CARRY      3'h2
`define OP_AND            3'h3
`define OP_SHIFT          3'h4
`define OP_BIT_CLEAR      3'h5
`define OP_PTR_ADD        3'h6

// indirect data port file addresses
`define INDIRECT_PORT0    7'h00
`define INDIRECT_PORT1    7'h01

`endif

/* File: core/alu_unit.v */
`timescale 1ns/1ps
`include "alu_defines.vh"

module alu_unit (
  // operation select and operands
  input  wire [2:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] operand,
  input  wire       carry_in,
  input  wire [2:0] bit_sel,
  // result and flags
  output reg  [7:0] result,
  output reg        carry_out,
  output reg        digit_carry_out,
  output reg        zero_out,
  output reg        upd_carry,
  output reg        upd_digit_carry,
  output reg        upd_zero
);

  reg [8:0] sum;
  reg [4:0] low_sum;
  reg [7:0] clear_mask;

  always @* begin
    sum             = 9'h000;
    low_sum         = 5'h00;
    clear_mask      = 8'h01 << bit_sel;
    result          = 8'h00;
    carry_out       = 1'b0;
    digit_carry_out = 1'b0;
    upd_carry       = 1'b0;
    upd_digit_carry = 1'b0;
    upd_zero        = 1'b0;
    case (op)
      `OP_ADD, `OP_ADD_CARRY: begin
        sum     = {1'b0, acc} + {1'b0, operand} +
                  {8'h00, (op == `OP_ADD_CARRY) & carry_in};
        low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} +
                  {4'h0, (op == `OP_ADD_CARRY) & carry_in};
        result          = sum[7:0];
        carry_out       = sum[8];
        digit_carry_out = low_sum[`OPC_NIBBLE_CARRY];
        upd_carry       = 1'b1;
        upd_digit_carry = 1'b1;
        upd_zero        = 1'b1;
      end
      `OP_AND: begin
        result   = acc & operand;
        upd_zero = 1'b1;
      end
      `OP_SHIFT: begin
        result    = {operand[7], operand[7:1]};
        carry_out = operand[0];
        upd_carry = 1'b1;
        upd_zero  = 1'b1;
      end
      `OP_BIT_CLEAR: begin
        result = operand & ~clear_mask;
      end
      default: begin
        result = 8'h00;
      end
    endcase
    zero_out = (result == 8'h00);
  end

endmodule

/* File: core/alu_exec.v */
`timescale 1ns/1ps
`include "alu_defines.vh"

module alu_exec #(
  parameter FILE_DEPTH = 128
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // core state
  output wire        busy
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_EXEC = 3'b100;

  reg  [2:0]  state;
  reg  [13:0] instr;
  reg  [7:0]  acc;
  reg         carry;
  reg         digit_carry;
  reg         zero;
  reg  [15:0] ptr0;
  reg  [15:0] ptr1;
  reg  [7:0]  file_mem [0:FILE_DEPTH-1];

  reg  [2:0]  op;
  reg         lit_op;
  wire [7:0]  alu_result;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_z;
  wire        upd_c;
  wire        upd_dc;
  wire        upd_z;

  ////////////////////////////////////////////////////////////////////////////
  // address helpers

  function is_indirect;
    input [6:0] addr;
    begin
      is_indirect = (addr == `INDIRECT_PORT0) || (addr == `INDIRECT_PORT1);
    end
  endfunction

  function [6:0] effective_addr;
    input [6:0]  addr;
    input [15:0] p0;
    input [15:0] p1;
    begin
      if (addr == `INDIRECT_PORT0)
        effective_addr = p0[6:0];
      else if (addr == `INDIRECT_PORT1)
        effective_addr = p1[6:0];
      else
        effective_addr = addr;
    end
  endfunction

  function file_window;
    input [11:0] addr;
    begin
      file_window = (addr >= `ADDR_FILE_BASE) && (addr <= `ADDR_FILE_TOP);
    end
  endfunction

  // opcodes that address a file register
  function uses_file;
    input [13:0] code;
    begin
      uses_file = (code[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_ADD_REG) ||
                  (code[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_AND_REG) ||
                  (code[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_ADD_CARRY) ||
                  (code[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ARITH_SHIFT) ||
                  (code[13:10] == `OPC_BIT_CLEAR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode

  always @* begin
    op     = `OP_NONE;
    lit_op = 1'b0;
    if (instr[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_ADD_LIT) begin
      op     = `OP_ADD;
      lit_op = 1'b1;
    end else if (instr[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_AND_LIT) begin
      op     = `OP_AND;
      lit_op = 1'b1;
    end else if (instr[13:7] == `OPC_PTR_ADD) begin
      op     = `OP_PTR_ADD;
      lit_op = 1'b1;
    end else if (instr[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_ADD_REG) begin
      op = `OP_ADD;
    end else if (instr[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_ADD_CARRY) begin
      op = `OP_ADD_CARRY;
    end else if (instr[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ACC_AND_REG) begin
      op = `OP_AND;
    end else if (instr[`OPC_TOP6_MSB:`OPC_TOP6_LSB] == `OPC_ARITH_SHIFT) begin
      op = `OP_SHIFT;
    end else if (instr[13:10] == `OPC_BIT_CLEAR) begin
      op = `OP_BIT_CLEAR;
    end
  end

  wire [6:0]  file_addr = effective_addr(instr[6:0], ptr0, ptr1);
  wire [7:0]  file_val  = file_mem[file_addr];
  wire        dest_file = instr[`OPC_DEST_BIT] | (op == `OP_BIT_CLEAR);
  wire [15:0] ptr_sel   = instr[`OPC_PTR_SEL_BIT] ? ptr1 : ptr0;
  wire [15:0] ptr_sum   = ptr_sel + {{10{instr[5]}}, instr[5:0]};

  alu_unit u_alu (
    .op              (op),
    .acc             (acc),
    .operand         (lit_op ? instr[7:0] : file_val),
    .carry_in        (carry),
    .bit_sel         (instr[9:7]),
    .result          (alu_result),
    .carry_out       (alu_c),
    .digit_carry_out (alu_dc),
    .zero_out        (alu_z),
    .upd_carry       (upd_c),
    .upd_digit_carry (upd_dc),
    .upd_zero        (upd_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire acc_phase = psel & penable;
  wire wr        = acc_phase & pwrite;
  wire mapped    = (paddr == `ADDR_INSTR) || (paddr == `ADDR_ACC) ||
                   (paddr == `ADDR_STATUS) || (paddr == `ADDR_PTR0) ||
                   (paddr == `ADDR_PTR1) || (file_window(paddr) && paddr[1:0] == 2'h0);
  wire start     = wr & (paddr == `ADDR_INSTR) & state[0];
  wire exec      = state[2];
  wire [13:0] new_instr = pwdata[13:0];
  wire new_extra = uses_file(new_instr) &&
                   is_indirect(new_instr[6:0]) &&
                   ((new_instr[6:0] == `INDIRECT_PORT1) ? ptr1[15] : ptr0[15]);

  assign pready  = 1'b1;
  assign pslverr = acc_phase & ~mapped;
  assign busy    = ~state[0];

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      instr <= 14'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            instr <= new_instr;
            state <= new_extra ? ST_WAIT : ST_EXEC;
          end
        end
        ST_WAIT: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural state

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc         <= 8'h00;
      carry       <= 1'b0;
      digit_carry <= 1'b0;
      zero        <= 1'b0;
      ptr0        <= 16'h0000;
      ptr1        <= 16'h0000;
    end else if (exec) begin
      if (op == `OP_PTR_ADD) begin
        if (instr[`OPC_PTR_SEL_BIT])
          ptr1 <= ptr_sum;
        else
          ptr0 <= ptr_sum;
      end else if (op != `OP_NONE) begin
        if (lit_op || !dest_file)
          acc <= alu_result;
        if (upd_c)
          carry <= alu_c;
        if (upd_dc)
          digit_carry <= alu_dc;
        if (upd_z)
          zero <= alu_z;
      end
    end else if (wr) begin
      if (paddr == `ADDR_ACC)
        acc <= pwdata[7:0];
      if (paddr == `ADDR_STATUS) begin
        carry       <= pwdata[`ST_CARRY];
        digit_carry <= pwdata[`ST_DIGIT_CARRY];
        zero        <= pwdata[`ST_ZERO];
      end
      if (paddr == `ADDR_PTR0)
        ptr0 <= pwdata[15:0];
      if (paddr == `ADDR_PTR1)
        ptr1 <= pwdata[15:0];
    end
  end

  // file registers, execution wins over bus
  always @(posedge pclk) begin
    if (exec && !lit_op && op != `OP_NONE && dest_file)
      file_mem[file_addr] <= alu_result;
    else if (wr && file_window(paddr))
      file_mem[paddr[8:2]] <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in setup phase

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `ADDR_INSTR)
        prdata <= {18'h00000, instr};
      else if (paddr == `ADDR_ACC)
        prdata <= {24'h000000, acc};
      else if (paddr == `ADDR_STATUS)
        prdata <= {28'h0000000, busy, zero, digit_carry, carry};
      else if (paddr == `ADDR_PTR0)
        prdata <= {16'h0000, ptr0};
      else if (paddr == `ADDR_PTR1)
        prdata <= {16'h0000, ptr1};
      else if (file_window(paddr))
        prdata <= {24'h000000, file_mem[paddr[8:2]]};
      else
        prdata <= 32'h00000000;
    end
  end

endmodule

/* File: bench/alu_exec_assertions.sv */
`timescale 1ns/1ps
`include "alu_defines.vh"
module alu_exec_checker (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  // core state
  input wire        busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire take = psel && penable;
  wire go   = take && pwrite && paddr == `ADDR_INSTR && !busy;
  wire hole = paddr > `ADDR_PTR1 && paddr < `ADDR_FILE_BASE;
  ////////////////////////////////////////
  property p_ready;
    take |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_hole;
    take && hole |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped access not refused");
  property p_mapped;
    take && paddr <= `ADDR_PTR1 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_upper;
    take && !pwrite |-> prdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_start;
    go |=> busy;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_one;
    go && pwdata[6:1] != 6'h00 |=> busy ##1 !busy;
  endproperty
  a_one: assert property (p_one) else $error("direct op not one cycle");
  property p_len;
    $rose(busy) |=> !busy or (busy ##1 !busy);
  endproperty
  a_len: assert property (p_len) else $error("op too long");
  property p_stat;
    psel && !penable && !pwrite && paddr == `ADDR_STATUS
      |=> prdata[3] == $past(busy) && prdata[31:4] == 28'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status busy bit wrong");
endmodule

bind alu_exec alu_exec_checker chk_u (
  .pclk    (pclk),
  .presetn (presetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .pready  (pready),
  .pslverr (pslverr),
  .prdata  (prdata),
  .busy    (busy)
);

/* File: bench/test_alu_exec.sv */
`timescale 1ns/1ps
`include "alu_defines.vh"
module test_alu_exec;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire         pready;
  wire         pslverr;
  wire  [31:0] prdata;
  wire         busy;
  int          error_cnt;
  int          checks_done;
  logic [31:0] busy_cnt;
  int          b;
  localparam logic [11:0] F5 = `ADDR_FILE_BASE + 12'h014;
  localparam logic [11:0] F6 = `ADDR_FILE_BASE + 12'h018;
  localparam logic [11:0] F7 = `ADDR_FILE_BASE + 12'h01C;

  alu_exec dut_u (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .busy    (busy)
  );

  always #25 pclk = ~pclk;
  always @(posedge pclk) busy_cnt <= busy_cnt + busy;
  ////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  // busy cycles counted around one instruction
  task exec(input [13:0] w, input int cyc);
    logic [31:0] n0;
    n0 = busy_cnt;
    wr(`ADDR_INSTR, {18'h0, w});
    repeat (2) @(posedge pclk);
    chk(busy_cnt - n0, cyc);
  endtask
  task final_report;
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    final_report;
  end
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    error_cnt   = 0;
    checks_done = 0;
    busy_cnt    = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ADDR_STATUS, 32'h0);
    wr(`ADDR_ACC, 32'h80);
    exec({`OPC_ACC_ADD_LIT, 8'h80}, 1);
    rd(`ADDR_ACC, 32'h0);
    rd(`ADDR_STATUS, 32'h5);
    wr(`ADDR_ACC, 32'h0C);
    wr(F5, 32'h3A);
    exec({`OPC_ACC_ADD_REG, 1'b1, 7'h05}, 1);
    rd(F5, 32'h46);
    rd(`ADDR_ACC, 32'h0C);
    rd(`ADDR_STATUS, 32'h2);
    wr(`ADDR_STATUS, 32'h1);
    exec({`OPC_ACC_ADD_CARRY, 1'b0, 7'h05}, 1);
    rd(`ADDR_ACC, 32'h53);
    rd(`ADDR_STATUS, 32'h2);
    wr(`ADDR_STATUS, 32'h3);
    exec({`OPC_ACC_AND_LIT, 8'hAC}, 1);
    rd(`ADDR_STATUS, 32'h7);
    wr(`ADDR_ACC, 32'hF0);
    exec({`OPC_ACC_AND_REG, 1'b1, 7'h05}, 1);
    rd(F5, 32'h40);
    rd(`ADDR_STATUS, 32'h3);
    wr(F6, 32'h80);
    exec({`OPC_ARITH_SHIFT, 1'b0, 7'h06}, 1);
    rd(`ADDR_ACC, 32'hC0);
    rd(`ADDR_STATUS, 32'h2);
    wr(F7, 32'hFF);
    for (b = 0; b < 8; b++) begin
      exec({`OPC_BIT_CLEAR, b[2:0], 7'h07}, 1);
      rd(F7, 32'hFF & (32'hFF << (b + 1)));
    end
    wr(`ADDR_PTR1, 32'hFFF0);
    exec({`OPC_PTR_ADD, 1'b0, 6'h20}, 1);
    exec({`OPC_PTR_ADD, 1'b1, 6'h1F}, 1);
    rd(`ADDR_PTR0, 32'hFFE0);
    rd(`ADDR_PTR1, 32'h000F);
    rd(`ADDR_STATUS, 32'h2);
    wr(`ADDR_PTR0, 32'h8005);
    exec({`OPC_ACC_ADD_REG, 1'b0, `INDIRECT_PORT0}, 2);
    rd(`ADDR_ACC, 32'h0);
    rd(`ADDR_STATUS, 32'h5);
    rd(12'h100, 32'h0);
    final_report;
  end
endmodule
